/* hw/pmic_io_pkg.sv */
package pmic_io_pkg;
    // synchroniser depth for pin and power-good inputs
    localparam int SYNC_STAGES = 2;
    // reset values of the configuration and user bits
    localparam logic RST_MEMORY_RESET_MODE_SELECT = 1'b0;
    localparam logic RST_OUT_BUFFER_TYPE_SELECT   = 1'b0;
    localparam logic RST_CORE_RAIL_RESET_ENABLE   = 1'b0;
    localparam logic RST_PIN_ONE_USER_LEVEL       = 1'b1;
    localparam logic RST_PIN_TWO_USER_LEVEL       = 1'b1;
    localparam logic RST_PIN_THREE_USER_LEVEL     = 1'b1;
    // register offsets of the local control and status registers
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_USER   = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_SEQ    = 4'h3;
    // config register field positions
    localparam int CFG_MEM_MODE_BIT = 0;
    localparam int CFG_BUF_TYPE_BIT = 1;
    localparam int CFG_RAIL_RST_BIT = 2;
    // user register field positions
    localparam int USR_ONE_BIT   = 0;
    localparam int USR_TWO_BIT   = 1;
    localparam int USR_THREE_BIT = 2;
    // sequencer-control register field positions
    localparam int SEQ_ONE_OWN_BIT   = 0;
    localparam int SEQ_THREE_OWN_BIT = 1;
    // status register field positions
    localparam int STS_PIN_ONE_BIT   = 0;
    localparam int STS_PIN_THREE_BIT = 1;
    localparam int STS_MAIN_POWER_GOOD_BIT     = 2;
    localparam int STS_OUT_LVL_BIT   = 3;
    localparam int STS_LATCHED_BIT   = 4;
    // read value of an unmapped address
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // memory reset output source states
    typedef enum logic [2:0] {
        DDR_HOLD_LOW = 3'b001,
        DDR_FOLLOW   = 3'b010,
        DDR_LATCHED  = 3'b100
    } ddr_state_t;
endpackage : pmic_io_pkg

/* hw/pin_sync.sv */
// two-stage synchroniser for a bundle of asynchronous levels
module pin_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // asynchronous and synchronised levels
    input  wire logic [WIDTH-1:0] i_async,
    input  wire logic [WIDTH-1:0] i_init,
    output logic      [WIDTH-1:0] o_sync
);
    import pmic_io_pkg::*;

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic             seeded_r;

    // refuse an empty bundle at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second; stages reset low, then seeded once
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r   <= '0;
            sync_r   <= '0;
            seeded_r <= 1'b0;
        end else begin
            meta_r   <= i_async;
            sync_r   <= seeded_r ? meta_r : i_init;
            seeded_r <= 1'b1;
        end
    end

    assign o_sync = sync_r;
endmodule : pin_sync

/* hw/pmic_io_ddr_reset_config.sv */
// Overview of operation
// - memory mode off: pin one is open drain, low on 0, released on 1.
// - pin one level comes from its user bit or from the sequencer.
// - memory mode, power good high: pin one is input, output pin copies it.
// - memory mode, after reset until power good rises: output pin driven low.
// - memory mode, power good falls: latch output level, hold while power good low.
// - memory mode off: output pin follows its own user bit.
// - output pin buffer selectable between open drain and push-pull.
// - pin three open drain output from user bit or sequencer.
// - pin three may instead be a reset input for both core bucks.
// - buffer select 0 gives open drain, 1 gives push-pull.
// - rail reset enabled: each pin three falling edge restores both core buck defaults.
module pmic_io_ddr_reset_config (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // register port
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // power sequencer levels and main power good
    input  wire logic       i_seq_pin_one_level,
    input  wire logic       i_seq_pin_three_level,
    input  wire logic       i_main_power_good,
    // ddr_reset_io_pin
    input  wire logic       i_ddr_reset_io_pin,
    output logic            o_ddr_reset_io_pin,
    output logic            o_ddr_reset_io_pin_oe,
    // ddr_reset_out_pin
    output logic            o_ddr_reset_out_pin,
    output logic            o_ddr_reset_out_pin_oe,
    // rail_reset_io_pin
    input  wire logic       i_rail_reset_io_pin,
    output logic            o_rail_reset_io_pin,
    output logic            o_rail_reset_io_pin_oe,
    // core buck voltage register reset pulses
    output logic            o_core_buck_a_restore,
    output logic            o_core_buck_b_restore
);
    import pmic_io_pkg::*;

    // configuration and user bits
    logic memory_reset_mode_select_r, memory_reset_mode_select_nxt;
    logic out_buffer_type_select_r, out_buffer_type_select_nxt;
    logic core_rail_reset_enable_r, core_rail_reset_enable_nxt;
    logic pin_one_user_level_r, pin_one_user_level_nxt;
    logic pin_two_user_level_r, pin_two_user_level_nxt;
    logic pin_three_user_level_r, pin_three_user_level_nxt;
    logic seq_owns_one_r, seq_owns_one_nxt;
    logic seq_owns_three_r, seq_owns_three_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    // synchronised inputs and edge history
    logic [2:0] sync_lvl;
    logic       pin_one_s, pin_three_s, main_power_good_s;
    logic       main_power_good_d_r, main_power_good_d_nxt;
    logic       pin_three_d_r, pin_three_d_nxt;

    // memory reset output path
    ddr_state_t ddr_state_r, ddr_state_nxt;
    logic       ddr_level_r, ddr_level_nxt;
    logic       restore_r, restore_nxt;

    // pin outputs
    logic out_one_r, out_one_nxt, oe_one_r, oe_one_nxt;
    logic out_two_r, out_two_nxt, oe_two_r, oe_two_nxt;
    logic out_three_r, out_three_nxt, oe_three_r, oe_three_nxt;

    // read mux decode
    function automatic logic [7:0] read_word(input logic [3:0] addr, input logic [7:0] cfg,
                                             input logic [7:0] usr, input logic [7:0] seq,
                                             input logic [7:0] sts);
        case (addr)
            ADDR_CONFIG: read_word = cfg;
            ADDR_USER:   read_word = usr;
            ADDR_SEQ:    read_word = seq;
            ADDR_STATUS: read_word = sts;
            default:     read_word = UNMAPPED_READ;
        endcase
    endfunction : read_word

    // synchronisers seeded with idle-high levels and power good low
    pin_sync #(
        .WIDTH (3)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async ({i_main_power_good, i_rail_reset_io_pin, i_ddr_reset_io_pin}),
        .i_init  (3'b011),
        .o_sync  (sync_lvl)
    );
    assign pin_one_s   = sync_lvl[0];
    assign pin_three_s = sync_lvl[1];
    assign main_power_good_s     = sync_lvl[2];

    // register writes and read data
    always_comb begin
        logic [7:0] cfg, usr, seq, sts;
        cfg = '0;
        usr = '0;
        seq = '0;
        sts = '0;
        memory_reset_mode_select_nxt = memory_reset_mode_select_r;
        out_buffer_type_select_nxt   = out_buffer_type_select_r;
        core_rail_reset_enable_nxt   = core_rail_reset_enable_r;
        pin_one_user_level_nxt       = pin_one_user_level_r;
        pin_two_user_level_nxt       = pin_two_user_level_r;
        pin_three_user_level_nxt     = pin_three_user_level_r;
        seq_owns_one_nxt             = seq_owns_one_r;
        seq_owns_three_nxt           = seq_owns_three_r;
        if (i_wr && i_addr == ADDR_CONFIG) begin
            memory_reset_mode_select_nxt = i_wdata[CFG_MEM_MODE_BIT];
            out_buffer_type_select_nxt   = i_wdata[CFG_BUF_TYPE_BIT];
            core_rail_reset_enable_nxt   = i_wdata[CFG_RAIL_RST_BIT];
        end
        if (i_wr && i_addr == ADDR_USER) begin
            pin_one_user_level_nxt   = i_wdata[USR_ONE_BIT];
            pin_two_user_level_nxt   = i_wdata[USR_TWO_BIT];
            pin_three_user_level_nxt = i_wdata[USR_THREE_BIT];
        end
        if (i_wr && i_addr == ADDR_SEQ) begin
            seq_owns_one_nxt   = i_wdata[SEQ_ONE_OWN_BIT];
            seq_owns_three_nxt = i_wdata[SEQ_THREE_OWN_BIT];
        end
        cfg[CFG_MEM_MODE_BIT]  = memory_reset_mode_select_r;
        cfg[CFG_BUF_TYPE_BIT]  = out_buffer_type_select_r;
        cfg[CFG_RAIL_RST_BIT]  = core_rail_reset_enable_r;
        usr[USR_ONE_BIT]       = pin_one_user_level_r;
        usr[USR_TWO_BIT]       = pin_two_user_level_r;
        usr[USR_THREE_BIT]     = pin_three_user_level_r;
        seq[SEQ_ONE_OWN_BIT]   = seq_owns_one_r;
        seq[SEQ_THREE_OWN_BIT] = seq_owns_three_r;
        sts[STS_PIN_ONE_BIT]   = pin_one_s;
        sts[STS_PIN_THREE_BIT] = pin_three_s;
        sts[STS_MAIN_POWER_GOOD_BIT]     = main_power_good_s;
        sts[STS_OUT_LVL_BIT]   = ddr_level_r;
        sts[STS_LATCHED_BIT]   = (ddr_state_r == DDR_LATCHED);
        rdata_nxt = i_rd ? read_word(i_addr, cfg, usr, seq, sts) : '0;
    end

    // memory reset output source: hold low, follow host, or latched
    always_comb begin
        ddr_state_nxt   = ddr_state_r;
        ddr_level_nxt   = ddr_level_r;
        main_power_good_d_nxt     = main_power_good_s;
        pin_three_d_nxt = pin_three_s;
        case (ddr_state_r)
            DDR_HOLD_LOW: begin
                ddr_level_nxt = 1'b0;
                if (main_power_good_s) begin
                    ddr_state_nxt = DDR_FOLLOW;
                end
            end
            DDR_FOLLOW: begin
                if (!main_power_good_s && main_power_good_d_r) begin
                    ddr_state_nxt = DDR_LATCHED;
                end else begin
                    ddr_level_nxt = pin_one_s;
                end
            end
            DDR_LATCHED: begin
                if (main_power_good_s) begin
                    ddr_state_nxt = DDR_FOLLOW;
                    ddr_level_nxt = pin_one_s;
                end
            end
            default: begin
                ddr_state_nxt = DDR_HOLD_LOW;
                ddr_level_nxt = 1'b0;
            end
        endcase
        // falling edge of pin three restores core buck defaults
        restore_nxt = core_rail_reset_enable_r && pin_three_d_r && !pin_three_s;
    end

    // pin drive
    always_comb begin
        logic one_lvl, two_lvl, three_lvl;
        one_lvl   = seq_owns_one_r ? i_seq_pin_one_level : pin_one_user_level_r;
        three_lvl = seq_owns_three_r ? i_seq_pin_three_level : pin_three_user_level_r;
        two_lvl   = memory_reset_mode_select_r ? ddr_level_r : pin_two_user_level_r;
        // pin one open drain, or input in memory mode
        out_one_nxt = 1'b0;
        oe_one_nxt  = !memory_reset_mode_select_r && !one_lvl;
        // output pin buffer type
        out_two_nxt = two_lvl;
        oe_two_nxt  = out_buffer_type_select_r ? 1'b1 : !two_lvl;
        // pin three is released when used as reset input
        out_three_nxt = 1'b0;
        oe_three_nxt  = !core_rail_reset_enable_r && !three_lvl;
    end

    // state registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            memory_reset_mode_select_r <= RST_MEMORY_RESET_MODE_SELECT;
            out_buffer_type_select_r   <= RST_OUT_BUFFER_TYPE_SELECT;
            core_rail_reset_enable_r   <= RST_CORE_RAIL_RESET_ENABLE;
            pin_one_user_level_r       <= RST_PIN_ONE_USER_LEVEL;
            pin_two_user_level_r       <= RST_PIN_TWO_USER_LEVEL;
            pin_three_user_level_r     <= RST_PIN_THREE_USER_LEVEL;
            seq_owns_one_r             <= 1'b0;
            seq_owns_three_r           <= 1'b0;
            rdata_r                    <= '0;
            main_power_good_d_r                  <= 1'b0;
            pin_three_d_r              <= 1'b1;
            ddr_state_r                <= DDR_HOLD_LOW;
            ddr_level_r                <= 1'b0;
            restore_r                  <= 1'b0;
            out_one_r                  <= 1'b0;
            oe_one_r                   <= 1'b0;
            out_two_r                  <= 1'b0;
            oe_two_r                   <= 1'b0;
            out_three_r                <= 1'b0;
            oe_three_r                 <= 1'b0;
        end else begin
            memory_reset_mode_select_r <= memory_reset_mode_select_nxt;
            out_buffer_type_select_r   <= out_buffer_type_select_nxt;
            core_rail_reset_enable_r   <= core_rail_reset_enable_nxt;
            pin_one_user_level_r       <= pin_one_user_level_nxt;
            pin_two_user_level_r       <= pin_two_user_level_nxt;
            pin_three_user_level_r     <= pin_three_user_level_nxt;
            seq_owns_one_r             <= seq_owns_one_nxt;
            seq_owns_three_r           <= seq_owns_three_nxt;
            rdata_r                    <= rdata_nxt;
            main_power_good_d_r                  <= main_power_good_d_nxt;
            pin_three_d_r              <= pin_three_d_nxt;
            ddr_state_r                <= ddr_state_nxt;
            ddr_level_r                <= ddr_level_nxt;
            restore_r                  <= restore_nxt;
            out_one_r                  <= out_one_nxt;
            oe_one_r                   <= oe_one_nxt;
            out_two_r                  <= out_two_nxt;
            oe_two_r                   <= oe_two_nxt;
            out_three_r                <= out_three_nxt;
            oe_three_r                 <= oe_three_nxt;
        end
    end

    // outputs from flip-flops
    assign o_rdata                = rdata_r;
    assign o_ddr_reset_io_pin     = out_one_r;
    assign o_ddr_reset_io_pin_oe  = oe_one_r;
    assign o_ddr_reset_out_pin    = out_two_r;
    assign o_ddr_reset_out_pin_oe = oe_two_r;
    assign o_rail_reset_io_pin    = out_three_r;
    assign o_rail_reset_io_pin_oe = oe_three_r;
    assign o_core_buck_a_restore  = restore_r;
    assign o_core_buck_b_restore  = restore_r;
endmodule : pmic_io_ddr_reset_config

/* bench/pmic_io_ddr_reset_config_properties.sv */
module pmic_io_ddr_reset_config_checker (
    // clock, reset and register port
    input wire logic       i_clk, i_rst, i_wr, i_rd,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata, o_rdata,
    // sequencer, power good and pins
    input wire logic       i_seq_pin_one_level, i_seq_pin_three_level, i_main_power_good,
    input wire logic       i_ddr_reset_io_pin, o_ddr_reset_io_pin, o_ddr_reset_io_pin_oe,
    input wire logic       o_ddr_reset_out_pin, o_ddr_reset_out_pin_oe,
    input wire logic       i_rail_reset_io_pin, o_rail_reset_io_pin, o_rail_reset_io_pin_oe,
    input wire logic       o_core_buck_a_restore, o_core_buck_b_restore
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cfg_r, usr_r, seq_r;
    logic [1:0] age_r;
    logic       pg_seen_r;
    wire        ok = (age_r == 2'd3);
    // shadow of the writable registers and settle counter after any write
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_r <= 8'h00; usr_r <= 8'h07; seq_r <= 8'h00; age_r <= 2'd0; pg_seen_r <= 1'b0;
        end else begin
            if (i_wr && i_addr == 4'h0) cfg_r <= i_wdata;
            if (i_wr && i_addr == 4'h1) usr_r <= i_wdata;
            if (i_wr && i_addr == 4'h3) seq_r <= i_wdata;
            age_r <= i_wr ? 2'd0 : (ok ? age_r : age_r + 2'd1);
            if (i_main_power_good) pg_seen_r <= 1'b1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence follow_hi; (ok && cfg_r[0] && i_main_power_good && i_ddr_reset_io_pin)[*6]; endsequence
    sequence follow_lo; (ok && cfg_r[0] && i_main_power_good && !i_ddr_reset_io_pin)[*6]; endsequence
    sequence rail_fall; ok && cfg_r[2] && $fell(i_rail_reset_io_pin) ##1 (!i_rail_reset_io_pin)[*2]; endsequence
    AST_IO_ONE_DRIVE: assert property (ok && !cfg_r[0] && !seq_r[0] |->
        o_ddr_reset_io_pin_oe == !usr_r[0] && !o_ddr_reset_io_pin) else $error("pin one drive wrong");
    AST_IO_ONE_INPUT: assert property (ok && cfg_r[0] |-> !o_ddr_reset_io_pin_oe)
        else $error("pin one driven in memory mode");
    AST_OUT_USER: assert property (ok && !cfg_r[0] |-> o_ddr_reset_out_pin == usr_r[1])
        else $error("out pin ignores user bit");
    AST_OUT_BUF: assert property (ok |-> o_ddr_reset_out_pin_oe == (cfg_r[1] | !o_ddr_reset_out_pin))
        else $error("out pin buffer type wrong");
    AST_THREE_DRIVE: assert property (ok && !cfg_r[2] && !seq_r[1] |->
        o_rail_reset_io_pin_oe == !usr_r[2] && !o_rail_reset_io_pin) else $error("pin three drive wrong");
    AST_THREE_INPUT: assert property (ok && cfg_r[2] |-> !o_rail_reset_io_pin_oe)
        else $error("pin three driven while reset input");
    AST_HOLD_LOW: assert property (ok && cfg_r[0] && !pg_seen_r |-> !o_ddr_reset_out_pin)
        else $error("out pin not held low");
    AST_FOLLOW_HI: assert property (follow_hi |-> o_ddr_reset_out_pin)
        else $error("out pin not high");
    AST_FOLLOW_LO: assert property (follow_lo |-> !o_ddr_reset_out_pin)
        else $error("out pin not low");
    AST_LATCH: assert property ((ok && cfg_r[0] && !i_main_power_good)[*6] |-> $stable(o_ddr_reset_out_pin))
        else $error("latched level moved");
    AST_RESTORE_PAIR: assert property (o_core_buck_a_restore == o_core_buck_b_restore)
        else $error("restore pulses differ");
    AST_RESTORE_FALL: assert property (rail_fall |-> ##[0:4] o_core_buck_a_restore)
        else $error("no restore after fall");
    AST_RESTORE_ONE: assert property ($rose(o_core_buck_a_restore) |=> !o_core_buck_a_restore)
        else $error("restore pulse too long");
endmodule : pmic_io_ddr_reset_config_checker

bind pmic_io_ddr_reset_config pmic_io_ddr_reset_config_checker chk (.*);

/* bench/host_model.sv */
module host_model (
    // device pin outputs and host drive requests
    input  wire logic i_one_oe, i_out_oe, i_out_lvl, i_three_oe,
    input  wire logic i_drive_one, i_lvl_one, i_drive_three, i_lvl_three,
    // resolved pin levels, all lines pulled up
    output logic      o_one, o_out, o_three
);
    timeunit 1ns;
    timeprecision 1ps;
    // device pull-down wins; host drives only when asked, else the pull-up shows
    assign o_one   = i_one_oe ? 1'b0 : (i_drive_one ? i_lvl_one : 1'b1);
    assign o_out   = i_out_oe ? i_out_lvl : 1'b1;
    assign o_three = i_three_oe ? 1'b0 : (i_drive_three ? i_lvl_three : 1'b1);
endmodule : host_model

/* bench/pmic_io_ddr_reset_config_tb.sv */
module pmic_io_ddr_reset_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, s1 = 0, s3 = 0, pg = 0, d1 = 0, l1 = 1, d3 = 0, l3 = 1;
    logic [3:0] i_addr = 0;
    logic [7:0] i_wdata = 0, o_rdata;
    logic io_o, io_oe, out_l, out_oe, th_o, th_oe, ra, rb, w1, wo, w3, e, lat, pgp;
    logic [31:0] rs = 32'h6618, r;
    int fail_count = 0, n_checks = 0, cyc = 0, pulses = 0, exp_pulses = 0;
    int mreg[4] = '{0, 7, 0, 0};
    int mask[4] = '{7, 7, 0, 3};
    pmic_io_ddr_reset_config dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_seq_pin_one_level(s1), .i_seq_pin_three_level(s3),
        .i_main_power_good(pg), .i_ddr_reset_io_pin(w1), .o_ddr_reset_io_pin(io_o), .o_ddr_reset_io_pin_oe(io_oe),
        .o_ddr_reset_out_pin(out_l), .o_ddr_reset_out_pin_oe(out_oe), .i_rail_reset_io_pin(w3),
        .o_rail_reset_io_pin(th_o), .o_rail_reset_io_pin_oe(th_oe), .o_core_buck_a_restore(ra),
        .o_core_buck_b_restore(rb));
    host_model host (.i_one_oe(io_oe), .i_out_oe(out_oe), .i_out_lvl(out_l), .i_three_oe(th_oe), .i_drive_one(d1),
        .i_lvl_one(l1), .i_drive_three(d3), .i_lvl_three(l3), .o_one(w1), .o_out(wo), .o_three(w3));
    // clock, cycle ceiling and restore pulse count
    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (ra === 1'b1) pulses++;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : xs
    task automatic chk_reg(string n, logic [7:0] x, logic [7:0] g);
        n_checks++;
        if (g !== x) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask : chk_reg
    task automatic chk_pin(string n, logic x, logic g);
        n_checks++;
        if (g !== x) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", n, x, g);
        end
    endtask : chk_pin
    task automatic idle(int n);
        repeat (n) @(posedge i_clk);
    endtask : idle
    task automatic wr(int a, int d);
        @(posedge i_clk);
        i_wr <= 1; i_addr <= a[3:0]; i_wdata <= d[7:0];
        @(posedge i_clk);
        i_wr <= 0;
        if (a < 4) mreg[a] = d & mask[a];
    endtask : wr
    task automatic rchk(int a);
        @(posedge i_clk);
        i_rd <= 1; i_addr <= a[3:0];
        @(posedge i_clk);
        i_rd <= 0;
        // read data stand for this one cycle only; look mid-cycle, return on an edge
        @(negedge i_clk);
        chk_reg("read", (a < 4) ? mreg[a][7:0] : 8'h00, o_rdata);
        @(posedge i_clk);
    endtask : rchk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    initial begin
        idle(5);
        i_rst <= 0;
        idle(2);
        // reset values, then an unmapped write that must be ignored
        foreach (mask[a]) if (a != 2) rchk(a);
        wr(5, 'hFF);
        rchk(5);
        // user levels, open drain then push-pull
        for (int b = 0; b < 2; b++) begin
            wr(0, b * 2);
            repeat (6) begin
                wr(1, xs());
                idle(4);
                chk_pin("one", mreg[1][0], w1);
                chk_pin("out", mreg[1][1], wo);
                chk_pin("oe", b | !mreg[1][1], out_oe);
                chk_pin("three", mreg[1][2], w3);
            end
            rchk(0);
            rchk(1);
        end
        // sequencer owns pins one and three
        wr(3, 3);
        rchk(3);
        repeat (6) begin
            r = xs();
            s1 <= r[0]; s3 <= r[1];
            idle(6);
            chk_pin("seq one", r[0], w1);
            chk_pin("seq three", r[1], w3);
        end
        wr(3, 0);
        wr(1, 7);
        // rail reset input: pulses only while enabled
        for (int en = 1; en >= 0; en--) begin
            wr(0, en * 4);
            idle(4);
            repeat (2) begin
                d3 <= 1; l3 <= 0;
                idle(6);
                d3 <= 0; l3 <= 1;
                idle(6);
                exp_pulses += en;
            end
            chk_reg("pulses", exp_pulses[7:0], pulses[7:0]);
        end
        // memory reset mode: hold low, follow, latch; push-pull from the halfway point
        wr(0, 1);
        d1 <= 1;
        idle(6);
        chk_pin("hold", 1'b0, wo);
        e = 0;
        lat = 0;
        pgp = 0;
        for (int k = 0; k < 24; k++) begin
            if (k == 12) wr(0, 3);
            r = xs();
            pg <= r[0]; l1 <= r[1];
            idle(6);
            if (r[0]) e = r[1];
            lat = !r[0] && (lat || pgp);
            pgp = r[0];
            chk_pin("ddr out", e, wo);
            // status: latched, level, power good, pin three released high, pin one
            mreg[2] = {lat, e, r[0], 1'b1, r[1]};
            rchk(2);
        end
        wrap_up();
    end
endmodule : pmic_io_ddr_reset_config_tb
